/* File: hdl/ubrg_pkg.sv */
// constants and types shared by the baud rate generator files
package ubrg_pkg;
    // ---------------------------------------------------------------
    // register map, byte addresses
    // ---------------------------------------------------------------
    localparam logic [11:0] ADDR_TXCS = 12'h000;
    localparam logic [11:0] ADDR_RXCS = 12'h004;
    localparam logic [11:0] ADDR_DIV  = 12'h008;
    localparam logic [11:0] ADDR_STAT = 12'h00C;
    // ---------------------------------------------------------------
    // reset values and writable masks
    // ---------------------------------------------------------------
    localparam logic [7:0] TXCS_RST  = 8'h02;
    localparam logic [7:0] RXCS_RST  = 8'h00;
    localparam logic [7:0] DIV_RST   = 8'h00;
    localparam logic [7:0] TXCS_WMSK = 8'hF5;
    localparam logic [7:0] RXCS_WMSK = 8'hF8;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int MASTER_BIT = 7;
    localparam int SYNC_BIT   = 4;
    localparam int HS_BIT     = 2;
    localparam int ST_RX_BIT  = 0;
    localparam int ST_PH_LSB  = 8;
    localparam int ST_TMR_LSB = 16;
    // ---------------------------------------------------------------
    // timing: oscillator cycles per timer step, sub-ticks per bit
    // ---------------------------------------------------------------
    localparam logic [1:0] PRE_LIM_SLOW = 2'h3;
    localparam logic [1:0] PRE_LIM_FAST = 2'h0;
    localparam logic [3:0] PH_LAST      = 4'hF;
    localparam logic [3:0] SMP_FIRST    = 4'h7;
    localparam logic [3:0] SMP_LAST     = 4'h9;
    // ---------------------------------------------------------------
    // bus answer state
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        AP_IDLE = 2'b00,
        AP_ACK  = 2'b01
    } ubrg_apb_t;
endpackage

/* File: hdl/ubrg_majority.sv */
// three-sample majority detector on the synchronised receive level
`timescale 1ns/1ps
`default_nettype none
module ubrg_majority
    import ubrg_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // samples
    input  wire logic smp_en,
    input  wire logic smp_last,
    input  wire logic din,
    // voted level
    output logic      level
);
    typedef struct packed {
        logic [1:0] smp;
        logic       level;
    } ubrg_maj_t;

    ubrg_maj_t st;
    ubrg_maj_t next_st;

    function automatic logic vote(input logic a, input logic b,
                                  input logic c);
        vote = (a & b) | (a & c) | (b & c);
    endfunction

    always_comb begin
        next_st = st;
        if (smp_en) begin
            next_st.smp = {st.smp[0], din};
            if (smp_last) begin
                next_st.level = vote(st.smp[1], st.smp[0], din);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st <= '{smp: 2'h3, level: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;

    a_majority_vote: assert property (@(posedge mclk) disable iff (sys_rst)
        smp_en && smp_last |=> level ==
        vote($past(st.smp[1]), $past(st.smp[0]), $past(din)))
        else $error("voted level does not match the three samples");
endmodule
`default_nettype wire

/* File: hdl/ubrg_top.sv */
// serial port baud rate generator with apb registers and rx voting
//
// Function
// - one 8-bit generator serves both modes
// - divisor sets free-running 8-bit timer period
// - high speed bit ignored in synchronous mode
// - async low speed: fosc / 64(X+1)
// - async high speed: fosc / 16(X+1)
// - synchronous: fosc / 4(X+1)
// - ratios apply only when generating clock
// - divisor accepts 0 to 255
// - divisor write clears the timer at once
// - async receive pin voted by three samples
// - divisor resets to zero
// - high speed bit: 1 fast, 0 slow
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ubrg_top
    import ubrg_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // serial line
    input  wire logic        serial_receive_pin,
    // to transmit and receive logic
    output logic             bit_tick,
    output logic             sub_tick,
    output logic             rx_level,
    output logic [7:0]       transmit_control_status,
    output logic [7:0]       receive_control_status
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        ubrg_apb_t   apb;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic [7:0]  txcs;
        logic [7:0]  rxcs;
        logic [7:0]  div;
        logic [1:0]  pre;
        logic [7:0]  tmr;
        logic [3:0]  phase;
        logic        bit_tick;
        logic        sub_tick;
        logic        smp_en;
        logic        smp_last;
        logic        rx_s1;
        logic        rx_s2;
    } ubrg_state_t;

    ubrg_state_t st;
    ubrg_state_t next_st;

    logic        voted;
    logic        hs;
    logic        sync_mode;
    logic        master;
    logic [1:0]  pre_lim;
    logic        step;
    logic        ovf;
    logic        hit;
    logic        mapped;
    logic        wr_en;
    logic        wr_div;
    logic [31:0] rd_word;

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    always_comb begin
        hs        = st.txcs[HS_BIT];
        sync_mode = st.txcs[SYNC_BIT];
        master    = st.txcs[MASTER_BIT];
        // sync and async slow step every 4 cycles, async fast every one
        pre_lim   = (sync_mode || !hs) ? PRE_LIM_SLOW
                                       : PRE_LIM_FAST;
        step      = (st.pre == pre_lim);
        ovf       = step && (st.tmr == st.div);
    end

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    always_comb begin
        hit     = psel && penable;
        mapped  = (paddr == ADDR_TXCS) || (paddr == ADDR_RXCS) ||
                  (paddr == ADDR_DIV)  || (paddr == ADDR_STAT);
        wr_en   = hit && st.pready && pwrite && mapped && pstrb[0];
        wr_div  = wr_en && (paddr == ADDR_DIV);
        rd_word = 32'h0000_0000;
        case (paddr)
            ADDR_TXCS: begin
                rd_word[7:0] = st.txcs;
            end
            ADDR_RXCS: begin
                rd_word[7:0] = st.rxcs;
            end
            ADDR_DIV: begin
                rd_word[7:0] = st.div;
            end
            ADDR_STAT: begin
                rd_word[ST_RX_BIT]                 = voted;
                rd_word[ST_PH_LSB +: 4]            = st.phase;
                rd_word[ST_TMR_LSB +: 8]           = st.tmr;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_st = st;
        // answer one cycle into the access phase
        case (st.apb)
            AP_IDLE: begin
                next_st.pready = 1'b0;
                if (hit) begin
                    next_st.apb     = AP_ACK;
                    next_st.pready  = 1'b1;
                    next_st.prdata  = pwrite ? 32'h0000_0000 : rd_word;
                    next_st.pslverr = !mapped;
                end
            end
            AP_ACK: begin
                next_st.apb     = AP_IDLE;
                next_st.pready  = 1'b0;
                next_st.pslverr = 1'b0;
            end
            default: begin
                next_st.apb    = AP_IDLE;
                next_st.pready = 1'b0;
            end
        endcase

        // register writes, low byte lane only
        if (wr_en) begin
            case (paddr)
                ADDR_TXCS: begin
                    next_st.txcs = (st.txcs & ~TXCS_WMSK) |
                                   (pwdata[7:0] & TXCS_WMSK);
                end
                ADDR_RXCS: begin
                    next_st.rxcs = (st.rxcs & ~RXCS_WMSK) |
                                   (pwdata[7:0] & RXCS_WMSK);
                end
                ADDR_DIV: begin
                    next_st.div = pwdata[7:0];
                end
                default: begin
                    next_st.div = st.div;
                end
            endcase
        end

        // free-running timer with reload at expiry
        if (step) begin
            next_st.pre = 2'h0;
            if (ovf) begin
                next_st.tmr = 8'h00;
            end else begin
                next_st.tmr = st.tmr + 8'h01;
            end
        end else begin
            next_st.pre = st.pre + 2'h1;
        end

        // async: sixteen sub-ticks per bit
        if (ovf && !sync_mode) begin
            next_st.phase = st.phase + 4'h1;
        end

        // ticks, one cycle wide
        if (sync_mode) begin
            next_st.bit_tick = ovf && master;
        end else begin
            next_st.bit_tick = ovf && (st.phase == PH_LAST);
        end
        next_st.sub_tick = ovf && !sync_mode;
        next_st.smp_en   = ovf && !sync_mode &&
                           (st.phase >= SMP_FIRST) &&
                           (st.phase <= SMP_LAST);
        next_st.smp_last = st.phase == SMP_LAST;

        // new divisor restarts the period at once
        if (wr_div) begin
            next_st.pre   = 2'h0;
            next_st.tmr   = 8'h00;
            next_st.phase = 4'h0;
        end

        // receive pin synchroniser
        next_st.rx_s1 = serial_receive_pin;
        next_st.rx_s2 = st.rx_s1;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st          <= '0;
            st.apb      <= AP_IDLE;
            st.txcs     <= TXCS_RST;
            st.rxcs     <= RXCS_RST;
            st.div      <= DIV_RST;
            st.rx_s1    <= 1'b1;
            st.rx_s2    <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // majority detector
    // ---------------------------------------------------------------
    ubrg_majority u_maj (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .smp_en   (st.smp_en),
        .smp_last (st.smp_last),
        .din      (st.rx_s2),
        .level    (voted)
    );

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign pready                  = st.pready;
    assign prdata                  = st.prdata;
    assign pslverr                 = st.pslverr;
    assign bit_tick                = st.bit_tick;
    assign sub_tick                = st.sub_tick;
    assign rx_level                = voted;
    assign transmit_control_status = st.txcs;
    assign receive_control_status  = st.rxcs;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_quiet3;
        (!wr_en) [*3];
    endsequence

    sequence s_sync_tick0;
        bit_tick && sync_mode && master && st.div == 8'h00 && !wr_en;
    endsequence

    sequence s_slow_sub0;
        sub_tick && !hs && st.div == 8'h00 && !wr_en;
    endsequence

    a_div_reset_zero: assert property (@(posedge mclk)
        $fell(sys_rst) |-> st.div == DIV_RST)
        else $error("divisor not zero after reset");

    a_wr_clears_tmr: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_div |=> st.tmr == 8'h00 && st.pre == 2'h0)
        else $error("divisor write did not clear the timer");

    a_tmr_in_range: assert property (@(posedge mclk) disable iff (sys_rst)
        st.tmr <= st.div)
        else $error("timer passed the divisor");

    a_sync_period: assert property (@(posedge mclk) disable iff (sys_rst)
        s_sync_tick0 ##1 s_quiet3 |=> bit_tick)
        else $error("synchronous period is not four cycles");

    a_fast_period: assert property (@(posedge mclk) disable iff (sys_rst)
        sub_tick && hs && st.div == 8'h00 && !wr_en |=> sub_tick)
        else $error("fast sub-tick not every cycle");

    a_slow_period: assert property (@(posedge mclk) disable iff (sys_rst)
        s_slow_sub0 ##1 s_quiet3 |=> sub_tick)
        else $error("slow sub-tick not every four cycles");

    a_sync_hs_ignored: assert property (@(posedge mclk)
        disable iff (sys_rst)
        sync_mode && hs && st.pre == 2'h0 && !wr_en |=> st.pre == 2'h1)
        else $error("high speed bit changed synchronous rate");

    a_slave_no_tick: assert property (@(posedge mclk) disable iff (sys_rst)
        sync_mode && !master && !wr_en |=> !bit_tick)
        else $error("bit tick in synchronous slave mode");

    a_tick_one_cycle: assert property (@(posedge mclk)
        disable iff (sys_rst)
        bit_tick && !sync_mode |=> !bit_tick)
        else $error("asynchronous bit tick wider than one cycle");

    a_smp_window: assert property (@(posedge mclk) disable iff (sys_rst)
        st.smp_en |-> $past(st.phase) >= SMP_FIRST &&
        $past(st.phase) <= SMP_LAST)
        else $error("sample taken outside mid-bit window");

    a_pready_pulse: assert property (@(posedge mclk)
        disable iff (sys_rst) pready |=> !pready)
        else $error("bus answer wider than one cycle");

    a_reload_zero: assert property (@(posedge mclk)
        disable iff (sys_rst) ovf |=> st.tmr == 8'h00)
        else $error("timer did not reload after expiry");

    a_tmr_steps: assert property (@(posedge mclk)
        disable iff (sys_rst)
        step && !ovf && !wr_div |=> st.tmr == $past(st.tmr) + 8'h01)
        else $error("timer did not advance by one step");

    a_async_bit_phase: assert property (@(posedge mclk)
        disable iff (sys_rst)
        bit_tick && !sync_mode && !$past(sync_mode) |->
        $past(st.phase) == PH_LAST)
        else $error("asynchronous bit tick off the last sub-tick");

    a_sync_no_sub: assert property (@(posedge mclk)
        disable iff (sys_rst) sync_mode && !wr_en |=> !sub_tick)
        else $error("sub-tick in synchronous mode");

    a_rx_two_flops: assert property (@(posedge mclk)
        disable iff (sys_rst) st.rx_s2 == $past(st.rx_s1))
        else $error("receive pin skipped a synchroniser stage");

    a_vote_holds: assert property (@(posedge mclk)
        disable iff (sys_rst)
        !(st.smp_en && st.smp_last) |=> $stable(voted))
        else $error("voted level changed outside a vote");
endmodule
`default_nettype wire

/* File: verif/ubrg_line_model.sv */
// far-end serial transmitter driving the receive pin
`timescale 1ns/1ps
`default_nettype none
module ubrg_line_model (
    // clock
    input  wire logic mclk,
    // commanded level and one-cycle noise
    input  wire logic level_cmd,
    input  wire logic glitch,
    // serial line
    output wire logic line
);
    // idle line rests high, as a pulled-up serial line
    logic drv = 1'b1;
    always_ff @(posedge mclk) begin
        drv <= level_cmd ^ glitch;
    end
    assign line = drv;
endmodule
`default_nettype wire

/* File: verif/ubrg_tb_top.sv */
// bench for the baud generator: registers, tick periods, voting
`timescale 1ns/1ps
`default_nettype none
module ubrg_tb_top
    import ubrg_pkg::*;
;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic        level_cmd = 1'b1;
    logic        glitch = 1'b0;
    wire logic   pready, pslverr, bit_tick, sub_tick, rx_level, rx_pin;
    wire logic [31:0] prdata;
    wire logic [7:0]  txcs, rxcs;
    int          fails = 0;
    int          checks_done = 0;

    ubrg_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr),
        .serial_receive_pin(rx_pin), .bit_tick(bit_tick),
        .sub_tick(sub_tick), .rx_level(rx_level),
        .transmit_control_status(txcs), .receive_control_status(rxcs));
    ubrg_line_model u_line (.mclk(mclk), .level_cmd(level_cmd),
        .glitch(glitch), .line(rx_pin));

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic is_wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= is_wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // answer comes one cycle into the access phase
        chk("pready wait", 2, n);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, {24'h0, d}, rd, err);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                          input logic exp_err, input string nm);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(nm, exp, rd);
        chk("pslverr", {31'h0, exp_err}, {31'h0, err});
    endtask

    // cycles between two ticks of bit_tick or sub_tick
    task automatic per_chk(input logic sub, input int exp, input string nm);
        int n;
        n = 0;
        // skip a tick launched under the old setting
        @(posedge mclk);
        while ((sub ? sub_tick : bit_tick) !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while ((sub ? sub_tick : bit_tick) !== 1'b1 && n < 3000);
        chk(nm, exp, n);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_regs();
        rd_chk(ADDR_TXCS, {24'h0, TXCS_RST}, 1'b0, "txcs reset");
        rd_chk(ADDR_RXCS, 32'h0, 1'b0, "rxcs reset");
        rd_chk(ADDR_DIV, 32'h0, 1'b0, "divisor reset");
        rd_chk(12'h010, 32'h0, 1'b1, "unmapped read");
        wr(ADDR_DIV, 8'hA5);
        rd_chk(ADDR_DIV, 32'hA5, 1'b0, "divisor rw");
    endtask

    task automatic t_sync();
        int n;
        wr(ADDR_TXCS, 8'h90);
        wr(ADDR_DIV, 8'h00);
        per_chk(1'b0, 4, "sync x0");
        wr(ADDR_TXCS, 8'h94);
        per_chk(1'b0, 4, "sync hs ignored");
        wr(ADDR_DIV, 8'h05);
        per_chk(1'b0, 24, "sync x5");
        wr(ADDR_DIV, 8'hFF);
        per_chk(1'b0, 1024, "sync x255");
        wr(ADDR_TXCS, 8'h10);
        n = 0;
        repeat (1100) begin
            @(posedge mclk);
            if (bit_tick === 1'b1) n++;
        end
        chk("slave ticks", 0, n);
    endtask

    task automatic t_clear();
        int n;
        wr(ADDR_TXCS, 8'h90);
        wr(ADDR_DIV, 8'hFF);
        repeat (100) @(posedge mclk);
        wr(ADDR_DIV, 8'h02);
        n = 0;
        while (bit_tick !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        chk("tick soon after write", 1, n <= 15);
    endtask

    task automatic t_async();
        wr(ADDR_TXCS, 8'h00);
        wr(ADDR_DIV, 8'h01);
        per_chk(1'b0, 128, "async slow bit");
        per_chk(1'b1, 8, "async slow sub");
        wr(ADDR_TXCS, 8'h04);
        per_chk(1'b0, 32, "async fast bit");
        per_chk(1'b1, 2, "async fast sub");
        wr(ADDR_DIV, 8'h00);
        per_chk(1'b1, 1, "async fast sub x0");
    endtask

    task automatic t_vote();
        int n;
        wr(ADDR_TXCS, 8'h04);
        wr(ADDR_DIV, 8'h07);
        level_cmd <= 1'b0;
        repeat (400) @(posedge mclk);
        chk("voted low", 0, rx_level);
        n = 0;
        repeat (20) begin
            repeat (30) begin
                @(posedge mclk);
                if (rx_level !== 1'b0) n++;
            end
            glitch <= 1'b1;
            @(posedge mclk);
            glitch <= 1'b0;
        end
        chk("glitch rejected", 0, n);
        level_cmd <= 1'b1;
        repeat (400) @(posedge mclk);
        chk("voted high", 1, rx_level);
    endtask

    task automatic t_rst();
        wr(ADDR_DIV, 8'h33);
        wr(ADDR_TXCS, 8'hF5);
        wr(ADDR_RXCS, 8'hFF);
        sys_rst <= 1'b1;
        @(posedge mclk);
        chk("txcs pin", {24'h0, TXCS_WMSK | TXCS_RST}, {24'h0, txcs});
        chk("rxcs pin", {24'h0, RXCS_WMSK}, {24'h0, rxcs});
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        chk("txcs after reset", {24'h0, TXCS_RST}, {24'h0, txcs});
        chk("rxcs after reset", {24'h0, RXCS_RST}, {24'h0, rxcs});
        rd_chk(ADDR_DIV, 32'h0, 1'b0, "divisor after reset");
    endtask

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        t_regs();
        t_sync();
        t_clear();
        t_async();
        t_vote();
        t_rst();
        end_sim();
    end

    initial begin
        #100us;
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire
